// ===== rtl/fault_channel.sv
/*
 * One channel of the fault timing block: power state, inrush window,
 * current-limit fault counter and one-second cool-down.
 * Assumes a shared base tick enable and a synchronised shutdown level.
 */
`timescale 1ns/10ps
`default_nettype none
module fault_channel (
    // Clock and reset
    input  wire logic                 mclk_in,
    input  wire logic                 rst_in,
    // Timing
    input  wire logic                 tick_in,
    input  wire logic [1:0]           fault_code_in,
    input  wire logic [1:0]           inrush_code_in,
    // Channel controls
    input  wire logic                 double_foldback_select_in,
    input  wire logic                 limiting_in,
    input  wire logic                 power_on_cmd_in,
    input  wire logic                 power_off_cmd_in,
    input  wire logic                 shutdown_in,
    input  wire logic                 manual_mode_in,
    input  wire logic                 semiauto_mode_in,
    input  wire logic                 detect_en_in,
    input  wire logic                 class_en_in,
    // Status
    output logic                      power_out,
    output logic                      cool_down_out,
    output logic                      fault_off_out,
    output logic                      restart_detect_out
);

    // Fault time code to limit in base ticks
    function automatic logic [11:0] fault_limit(input logic [1:0] code);
        case (code)
            2'h0:    fault_limit = 12'(fault_timing_pkg::FAULT_CODE0_MS
                                   * fault_timing_pkg::TICKS_PER_MS);
            2'h1:    fault_limit = 12'(fault_timing_pkg::FAULT_CODE1_MS
                                   * fault_timing_pkg::TICKS_PER_MS);
            2'h2:    fault_limit = 12'(fault_timing_pkg::FAULT_CODE2_MS
                                   * fault_timing_pkg::TICKS_PER_MS);
            default: fault_limit = 12'(fault_timing_pkg::FAULT_CODE3_MS
                                   * fault_timing_pkg::TICKS_PER_MS);
        endcase
    endfunction : fault_limit

    // Inrush code to window in base ticks
    function automatic logic [14:0] inrush_limit(input logic [1:0] code);
        case (code)
            2'h0:    inrush_limit = 15'(fault_timing_pkg::INRUSH_CODE0_MS
                                    * fault_timing_pkg::TICKS_PER_MS);
            2'h1:    inrush_limit = 15'(fault_timing_pkg::INRUSH_CODE1_MS
                                    * fault_timing_pkg::TICKS_PER_MS);
            2'h2:    inrush_limit = 15'(fault_timing_pkg::INRUSH_CODE2_MS
                                    * fault_timing_pkg::TICKS_PER_MS);
            default: inrush_limit = 15'(fault_timing_pkg::INRUSH_CODE3_MS
                                    * fault_timing_pkg::TICKS_PER_MS);
        endcase
    endfunction : inrush_limit

    localparam logic [14:0] COOL_TICKS =
        15'(fault_timing_pkg::COOL_DOWN_MS * fault_timing_pkg::TICKS_PER_MS);
    localparam logic [11:0] NOMINAL_TICKS =
        12'(fault_timing_pkg::FAULT_NOMINAL_MS
            * fault_timing_pkg::TICKS_PER_MS);

    fault_timing_pkg::chan_state_t state;       // Channel power state
    logic [11:0]                   fault_cnt;   // Limiting time, base ticks
    logic [14:0]                   time_cnt;    // Inrush or cool-down time
    logic [14:0]                   win_limit;   // Inrush latched at turn-on
    logic [3:0]                    decay_div;   // Decrement prescaler
    logic [11:0]                   limit_now;   // Active time-out
    logic                          timeout;     // Fault counter expired
    logic                          turn_off;    // Command or shutdown off

    // Limit follows the live register, so a rewrite applies at once
    always_comb begin
        if (double_foldback_select_in) begin
            limit_now = fault_limit(fault_code_in);
        end else begin
            limit_now = NOMINAL_TICKS;
        end
    end

    assign timeout  = (state == fault_timing_pkg::CH_ON)
                      && (fault_cnt >= limit_now);
    assign turn_off = power_off_cmd_in || shutdown_in;

    // Channel state sequence
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state <= fault_timing_pkg::CH_OFF;
        end else begin
            case (state)
                fault_timing_pkg::CH_OFF: begin
                    if (power_on_cmd_in && !turn_off) begin
                        state <= fault_timing_pkg::CH_INRUSH;
                    end
                end
                fault_timing_pkg::CH_INRUSH: begin
                    if (turn_off) begin
                        state <= fault_timing_pkg::CH_OFF;
                    end else if (tick_in && time_cnt + 15'h1 >= win_limit)
                    begin
                        // Still limiting at window end means a fault
                        state <= limiting_in ? fault_timing_pkg::CH_COOL
                                             : fault_timing_pkg::CH_ON;
                    end
                end
                fault_timing_pkg::CH_ON: begin
                    if (turn_off) begin
                        state <= fault_timing_pkg::CH_OFF;
                    end else if (timeout) begin
                        state <= fault_timing_pkg::CH_COOL;
                    end
                end
                default: begin
                    // Shutdown leaves a running cool-down alone
                    if (manual_mode_in) begin
                        state <= fault_timing_pkg::CH_OFF;
                    end else if (tick_in && time_cnt + 15'h1 >= COOL_TICKS)
                    begin
                        state <= fault_timing_pkg::CH_OFF;
                    end
                end
            endcase
        end
    end

    // Inrush and cool-down timer, restarted on every state entry
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            time_cnt  <= 15'h0;
            win_limit <= 15'h0;
        end else if (state == fault_timing_pkg::CH_OFF
                     || state == fault_timing_pkg::CH_ON
                     || (state == fault_timing_pkg::CH_INRUSH
                         && tick_in && time_cnt + 15'h1 >= win_limit)
                     || (state == fault_timing_pkg::CH_COOL
                         && manual_mode_in)) begin
            time_cnt <= 15'h0;
            // Inrush setting sampled on every timer restart; the window uses the last sample taken while off
            win_limit <= inrush_limit(inrush_code_in);
        end else if (tick_in) begin
            time_cnt <= time_cnt + 15'h1;
        end
    end

    // Fault counter: up while limiting, down at a sixteenth otherwise
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            fault_cnt <= 12'h0;
            decay_div <= 4'h0;
        end else if (state != fault_timing_pkg::CH_ON || turn_off) begin
            fault_cnt <= 12'h0;
            decay_div <= 4'h0;
        end else if (tick_in && !timeout) begin
            if (limiting_in) begin
                fault_cnt <= fault_cnt + 12'h1;
            end else begin
                decay_div <= decay_div + 4'h1;
                if (decay_div == 4'hf && fault_cnt != 12'h0) begin
                    fault_cnt <= fault_cnt - 12'h1;
                end
            end
        end
    end

    // Registered status outputs
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            power_out          <= 1'b0;
            cool_down_out      <= 1'b0;
            fault_off_out      <= 1'b0;
            restart_detect_out <= 1'b0;
        end else begin
            power_out     <= state == fault_timing_pkg::CH_INRUSH
                             || state == fault_timing_pkg::CH_ON;
            cool_down_out <= state == fault_timing_pkg::CH_COOL;
            fault_off_out <= timeout && !turn_off;
            restart_detect_out <= state == fault_timing_pkg::CH_COOL
                && !manual_mode_in && semiauto_mode_in && detect_en_in
                && class_en_in && tick_in
                && time_cnt + 15'h1 >= COOL_TICKS;
        end
    end

    // Checks
    sequence s_fault_hit;
        state == fault_timing_pkg::CH_ON && timeout && !turn_off;
    endsequence

    a_timeout_cools: assert property (@(posedge mclk_in) disable iff (rst_in)
        s_fault_hit |=> state == fault_timing_pkg::CH_COOL ##1 !power_out)
        else $error("fault time-out did not power off");
    a_cool_blocks_on: assert property (@(posedge mclk_in) disable iff (rst_in)
        state == fault_timing_pkg::CH_COOL && !manual_mode_in
        && time_cnt < COOL_TICKS - 15'h1
        |=> state == fault_timing_pkg::CH_COOL)
        else $error("channel enabled during cool-down");
    a_count_gated: assert property (@(posedge mclk_in) disable iff (rst_in)
        state != fault_timing_pkg::CH_ON |=> fault_cnt == 12'h0)
        else $error("fault counter ran outside on state");
    a_count_up: assert property (@(posedge mclk_in) disable iff (rst_in)
        state == fault_timing_pkg::CH_ON && !turn_off && tick_in && limiting_in
        && !timeout |=> fault_cnt == $past(fault_cnt) + 12'h1)
        else $error("fault counter missed increment");
    a_decay_rate: assert property (@(posedge mclk_in) disable iff (rst_in)
        state == fault_timing_pkg::CH_ON && !limiting_in && !turn_off
        && decay_div != 4'hf |=> fault_cnt == $past(fault_cnt))
        else $error("fault counter decayed too fast");
    a_off_clears: assert property (@(posedge mclk_in) disable iff (rst_in)
        turn_off && state == fault_timing_pkg::CH_ON
        |=> fault_cnt == 12'h0 && state == fault_timing_pkg::CH_OFF)
        else $error("turn-off did not clear counter");
    a_nominal_limit: assert property (@(posedge mclk_in) disable iff (rst_in)
        !double_foldback_select_in |-> limit_now == 12'h3c0)
        else $error("nominal fault time not used");
    a_code_limit: assert property (@(posedge mclk_in) disable iff (rst_in)
        double_foldback_select_in && fault_code_in == 2'h3
        |-> limit_now == 12'h060)
        else $error("programmed fault time wrong");
    a_manual_clear: assert property (@(posedge mclk_in) disable iff (rst_in)
        state == fault_timing_pkg::CH_COOL && manual_mode_in
        |=> state == fault_timing_pkg::CH_OFF && time_cnt == 15'h0)
        else $error("manual mode kept cool-down");
    a_no_wrap: assert property (@(posedge mclk_in) disable iff (rst_in)
        $past(fault_cnt) == 12'h0 && state == fault_timing_pkg::CH_ON
        && !$past(limiting_in) |-> fault_cnt == 12'h0)
        else $error("fault counter wrapped below zero");

endmodule : fault_channel
`default_nettype wire

// ===== rtl/fault_timing_pkg.sv
/*
 * Shared constants for the channel fault timing block: the timing
 * configuration register, its field layout, reset value and timing counts.
 * Assumes a 40 MHz system clock; the other RTL files and the bench refer to names here.
 */
package fault_timing_pkg;

    // Register command address and reset value
    localparam logic [7:0] TIMING_CFG_CMD   = 8'h16;
    localparam logic [7:0] TIMING_CFG_RESET = 8'h00;

    // Field positions (low bit of each 2-bit field)
    localparam int FAULT_TIME_LSB   = 6;
    localparam int INRUSH_TIME_LSB  = 4;
    localparam int OVERLOAD_LSB     = 2;
    localparam int DISC_HOLD_LSB    = 0;

    // Clock and base tick (one sixteenth of a millisecond)
    localparam int CLK_PERIOD_NS    = 25;
    localparam int BASE_TICK_NS     = 62500;
    localparam int TICK_CYCLES      = (BASE_TICK_NS + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
    localparam int TICKS_PER_MS     = 16;

    // Fault times in ms: nominal and per field code
    localparam int FAULT_NOMINAL_MS = 60;
    localparam int FAULT_CODE0_MS   = 58;
    localparam int FAULT_CODE1_MS   = 15;
    localparam int FAULT_CODE2_MS   = 10;
    localparam int FAULT_CODE3_MS   = 6;

    // Inrush window per code in ms (plain defaults)
    localparam int INRUSH_CODE0_MS  = 60;
    localparam int INRUSH_CODE1_MS  = 30;
    localparam int INRUSH_CODE2_MS  = 120;
    localparam int INRUSH_CODE3_MS  = 200;

    // Cool-down period and fault counter decay divider
    localparam int COOL_DOWN_MS     = 1000;
    localparam int DECAY_DIV        = 16;

    // Counter widths
    localparam int FAULT_CNT_W      = 12;
    localparam int TIME_CNT_W       = 15;

    // Channel power state
    typedef enum logic [1:0] {
        CH_OFF,
        CH_INRUSH,
        CH_ON,
        CH_COOL
    } chan_state_t;

endpackage : fault_timing_pkg

// ===== rtl/fault_timing_top.sv
/*
 * Timing configuration register and four current-limit fault timers.
 * Assumes a host command port on the system clock and an asynchronous
 * fast shutdown pin, which is synchronised here.
 */
`timescale 1ns/10ps
`default_nettype none
module fault_timing_top #(
    parameter int CHANNELS = 4,
    parameter int TICK_LEN = fault_timing_pkg::TICK_CYCLES // Clocks a tick
) (
    // Clock and reset
    input  wire logic                mclk_in,
    input  wire logic                rst_in,
    // Register command port
    input  wire logic [7:0]          reg_cmd_in,
    input  wire logic                reg_wr_in,
    input  wire logic                reg_rd_in,
    input  wire logic [7:0]          reg_wdata_in,
    output logic      [7:0]          reg_rdata_out,
    output logic                     reg_rvalid_out,
    // Fast shutdown pin and channel selection
    input  wire logic                fast_shutdown_input_in,
    input  wire logic [CHANNELS-1:0] shutdown_sel_in,
    // Per-channel controls
    input  wire logic [CHANNELS-1:0] double_foldback_select_in,
    input  wire logic [CHANNELS-1:0] limiting_in,
    input  wire logic [CHANNELS-1:0] power_on_cmd_in,
    input  wire logic [CHANNELS-1:0] power_off_cmd_in,
    input  wire logic [CHANNELS-1:0] manual_mode_in,
    input  wire logic [CHANNELS-1:0] semiauto_mode_in,
    input  wire logic [CHANNELS-1:0] detect_en_in,
    input  wire logic [CHANNELS-1:0] class_en_in,
    // Per-channel status
    output logic      [CHANNELS-1:0] power_out,
    output logic      [CHANNELS-1:0] cool_down_out,
    output logic      [CHANNELS-1:0] fault_off_out,
    output logic      [CHANNELS-1:0] restart_detect_out
);

    // Divider end count; a short tick lets long spans be exercised
    localparam logic [11:0] TICK_LAST = 12'(TICK_LEN - 1);

    logic [7:0]  channel_timing_config;  // Shared timing byte
    logic [11:0] tick_div;               // Base tick divider
    logic        tick;                   // One-cycle base tick enable
    logic        shut_meta;              // Synchroniser first stage
    logic        shut_sync;              // Synchronised shutdown level

    // Timing byte: writable at its command, reset to zero
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            channel_timing_config <= fault_timing_pkg::TIMING_CFG_RESET;
        end else if (reg_wr_in
                     && reg_cmd_in == fault_timing_pkg::TIMING_CFG_CMD) begin
            channel_timing_config <= reg_wdata_in;
        end
    end

    // Read answer one cycle after the request; unknown commands read zero
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            reg_rdata_out  <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in
                && reg_cmd_in == fault_timing_pkg::TIMING_CFG_CMD) begin
                reg_rdata_out <= channel_timing_config;
            end else if (reg_rd_in) begin
                reg_rdata_out <= 8'h00;
            end
        end
    end

    // Base tick divider, one sixteenth of a millisecond
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            tick_div <= 12'h0;
            tick     <= 1'b0;
        end else begin
            tick     <= tick_div == TICK_LAST;
            tick_div <= (tick_div == TICK_LAST) ? 12'h0 : tick_div + 12'h1;
        end
    end

    // Pin is asynchronous, so two flops before any use
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            shut_meta <= 1'b0;
            shut_sync <= 1'b0;
        end else begin
            shut_meta <= fast_shutdown_input_in;
            shut_sync <= shut_meta;
        end
    end

    // One timer per channel, all sharing the timing byte
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
        fault_channel u_chan (
            .mclk_in                   (mclk_in),
            .rst_in                    (rst_in),
            .tick_in                   (tick),
            .fault_code_in             (channel_timing_config[
                fault_timing_pkg::FAULT_TIME_LSB +: 2]),
            .inrush_code_in            (channel_timing_config[
                fault_timing_pkg::INRUSH_TIME_LSB +: 2]),
            .double_foldback_select_in (double_foldback_select_in[ch]),
            .limiting_in               (limiting_in[ch]),
            .power_on_cmd_in           (power_on_cmd_in[ch]),
            .power_off_cmd_in          (power_off_cmd_in[ch]),
            .shutdown_in               (shut_sync && shutdown_sel_in[ch]),
            .manual_mode_in            (manual_mode_in[ch]),
            .semiauto_mode_in          (semiauto_mode_in[ch]),
            .detect_en_in              (detect_en_in[ch]),
            .class_en_in               (class_en_in[ch]),
            .power_out                 (power_out[ch]),
            .cool_down_out             (cool_down_out[ch]),
            .fault_off_out             (fault_off_out[ch]),
            .restart_detect_out        (restart_detect_out[ch])
        );
    end

    // Checks
    a_cfg_write: assert property (@(posedge mclk_in) disable iff (rst_in)
        reg_wr_in && reg_cmd_in == fault_timing_pkg::TIMING_CFG_CMD
        |=> channel_timing_config == $past(reg_wdata_in))
        else $error("timing byte write lost");
    a_tick_period: assert property (@(posedge mclk_in) disable iff (rst_in)
        tick |=> !tick [*8])
        else $error("base tick too frequent");

endmodule : fault_timing_top
`default_nettype wire

// ===== bench/host_model.sv
/*
 * Host model: issues strobed commands on the register port of the timing
 * block. Assumes callers stand just past a rising clock edge.
 */
`timescale 1ns/10ps
`default_nettype none
module host_model (
    // Clock
    input  wire logic       mclk_in,
    // Register command port toward the block
    output logic      [7:0] reg_cmd_out,
    output logic            reg_wr_out,
    output logic            reg_rd_out,
    output logic      [7:0] reg_wdata_out
);
    // Quiet port at time zero
    initial begin
        reg_cmd_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_wdata_out = 8'h00;
    end

    // One request held over one edge; returns just past the taking edge
    task automatic req(input logic wr, input logic rd,
                       input logic [7:0] cmd, input logic [7:0] wd);
        reg_cmd_out = cmd;
        reg_wr_out = wr;
        reg_rd_out = rd;
        reg_wdata_out = wd;
        @(posedge mclk_in);
        #1;
    endtask : req

    // Strobes drop; command and data flip so stale values never look live
    task automatic idle();
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_cmd_out = ~reg_cmd_out;
        reg_wdata_out = ~reg_wdata_out;
        @(posedge mclk_in);
        #1;
    endtask : idle
endmodule : host_model
`default_nettype wire

// ===== bench/pse_channel_fault_timing_bench.sv
/*
 * Self-checking bench for the timing byte and channel power control.
 * Runs the block with a ten-clock base tick so inrush and fault spans fit;
 * a full one-second cool-down is still too long and is not run.
 */
`timescale 1ns/10ps
`default_nettype none
module pse_channel_fault_timing_bench;
    // Design-facing signals
    logic       mclk_in, rst_in, rvalid, pin;
    logic [7:0] cmd, wd, rdata;
    logic       wr, rd;
    logic [3:0] sel, dfb, lim, on_cmd, off_cmd, man, semi, det, cls;
    logic [3:0] pwr, cool, foff, rst_det;
    // Bench state
    int         seed = 64978;
    int         n_fail = 0;
    int         checked = 0;
    logic [7:0] cfg, v, c;
    int         n = 0;
    // Shortened base tick and the spans it gives for codes used below
    localparam int TICK     = 10;
    localparam int INRUSH_T = fault_timing_pkg::INRUSH_CODE1_MS
                              * fault_timing_pkg::TICKS_PER_MS * TICK;
    localparam int FAULT_T  = fault_timing_pkg::FAULT_CODE3_MS
                              * fault_timing_pkg::TICKS_PER_MS * TICK;

    always #12.5 mclk_in = ~mclk_in;

    host_model host (.mclk_in(mclk_in), .reg_cmd_out(cmd), .reg_wr_out(wr),
        .reg_rd_out(rd), .reg_wdata_out(wd));

    fault_timing_top #(.TICK_LEN(TICK)) uut (.mclk_in(mclk_in),
        .rst_in(rst_in),
        .reg_cmd_in(cmd), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_wdata_in(wd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .fast_shutdown_input_in(pin), .shutdown_sel_in(sel),
        .double_foldback_select_in(dfb), .limiting_in(lim),
        .power_on_cmd_in(on_cmd), .power_off_cmd_in(off_cmd),
        .manual_mode_in(man), .semiauto_mode_in(semi), .detect_en_in(det),
        .class_en_in(cls), .power_out(pwr), .cool_down_out(cool),
        .fault_off_out(foff), .restart_detect_out(rst_det));

    // Expected read data: only the timing command answers
    function automatic logic [7:0] exp_read(input logic [7:0] a,
                                            input logic [7:0] b);
        return (a == fault_timing_pkg::TIMING_CFG_CMD) ? b : 8'h00;
    endfunction : exp_read

    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string what);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: %s seen %h expected %h", $time, what,
                     seen, exp);
        end
    endtask : check

    // Read strobe, then answer checked just past the taking edge
    task automatic read_chk(input logic [7:0] a, input logic [7:0] exp);
        host.req(1'b0, 1'b1, a, 8'($random(seed)));
        check({7'h00, rvalid}, 8'h01, "read valid");
        check(rdata, exp, "read data");
    endtask : read_chk

    // Wait, bounded, until the masked power bits are all low
    task automatic wait_off(input logic [3:0] m);
        for (int k = 0; k < 12 && (pwr & m) != 4'h0; k++) begin
            @(posedge mclk_in);
            #1;
        end
    endtask : wait_off

    task automatic tally_and_finish();
        $display("Counts: %0d checked, %0d failed", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    // Hang guard: the whole sequence needs well under 20000 cycles
    initial begin
        #(25 * 20000);
        n_fail++;
        $display("Error at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        mclk_in = 1'b0;
        rst_in = 1'b1;
        {pin, sel, dfb, lim, on_cmd, off_cmd, man, semi, det, cls} = '0;
        repeat (10) @(posedge mclk_in);
        #1;
        rst_in = 1'b0;
        // Reset values
        check({pwr, cool}, 8'h00, "status after reset");
        read_chk(8'h16, 8'h00);
        host.idle();
        check({7'h00, rvalid}, 8'h00, "valid drop");
        $display("Test reset done");
        // Writes with every fault code, stray commands, back-to-back reads
        cfg = 8'h00;
        for (int i = 0; i < 16; i++) begin
            v = 8'($random(seed));
            v = (i < 4) ? {i[1:0], v[5:0]} : v;
            c = (i % 3 == 2 && i > 3) ? 8'($random(seed)) : 8'h16;
            host.req(1'b1, 1'b0, c, v);
            cfg = (c == 8'h16) ? v : cfg;
            read_chk(8'h16, cfg);
            c = 8'($random(seed));
            read_chk(c, exp_read(c, cfg));
        end
        // Write and read in one cycle return the old byte
        host.req(1'b1, 1'b1, 8'h16, ~cfg);
        check(rdata, cfg, "same-cycle read");
        cfg = ~cfg;
        read_chk(8'h16, cfg);
        host.idle();
        $display("Test register done");
        // Per channel: turn on, inrush with limiting, turn off
        for (int ch = 0; ch < 4; ch++) begin
            {dfb, lim, det, cls, semi} = 20'($random(seed));
            on_cmd[ch] = 1'b1;
            @(posedge mclk_in);
            #1;
            on_cmd = 4'h0;
            for (int k = 0; k < 3; k++) begin
                check({7'h00, pwr[ch]}, {7'h00, k > 0}, "power on");
                @(posedge mclk_in);
                #1;
            end
            lim = 4'hf;
            repeat (20) @(posedge mclk_in);
            #1;
            check({foff, pwr[ch], cool[ch]}, 8'h02, "inrush hold");
            off_cmd[ch] = 1'b1;
            @(posedge mclk_in);
            #1;
            off_cmd = 4'h0;
            wait_off(4'h1 << ch);
            check({pwr, cool}, 8'h00, "turn off");
        end
        $display("Test channel done");
        // Shutdown pin drops only the selected channels, no cool-down
        on_cmd = 4'hf;
        @(posedge mclk_in);
        #1;
        on_cmd = 4'h0;
        repeat (4) @(posedge mclk_in);
        #1;
        sel = 4'($random(seed)) | 4'h2;
        sel[0] = 1'b0;
        pin = 1'b1;
        wait_off(sel);
        check({pwr, cool}, {~sel, 4'h0}, "shutdown");
        check({4'h0, foff}, 8'h00, "no fault pulse");
        pin = 1'b0;
        man = 4'hf;
        off_cmd = 4'hf;
        @(posedge mclk_in);
        #1;
        off_cmd = 4'h0;
        wait_off(4'hf);
        check({pwr, cool}, 8'h00, "manual off");
        $display("Test shutdown done");
        // Ch1 limits through inrush; ch0 and ch2 limit after it, and only
        // ch0 takes the programmed shortest fault time
        man = 4'h0;
        {semi, det, cls} = 12'hfff;
        host.req(1'b1, 1'b0, 8'h16, 8'hd0);
        host.idle();
        dfb = 4'h1;
        lim = 4'h2;
        on_cmd = 4'h7;
        @(posedge mclk_in);
        #1;
        on_cmd = 4'h0;
        repeat (INRUSH_T - 3 * TICK) @(posedge mclk_in);
        #1;
        check({cool, pwr}, 8'h07, "inrush span");
        repeat (6 * TICK) @(posedge mclk_in);
        #1;
        check({cool, pwr}, 8'h25, "inrush fault");
        lim = 4'h7;
        n = 0;
        while (!foff[0] && n < 2 * FAULT_T) begin
            @(posedge mclk_in);
            #1;
            n++;
        end
        check({7'h00, n > FAULT_T - TICK && n <= FAULT_T + 2 * TICK},
              8'h01, "fault span");
        @(posedge mclk_in);
        #1;
        check({cool, pwr}, 8'h34, "fault off");
        check({4'h0, foff}, 8'h00, "pulse ends");
        check({7'h00, pwr[2]}, 8'h01, "nominal time");
        // Turn-on during cool-down is refused, manual mode cancels it
        on_cmd = 4'h3;
        @(posedge mclk_in);
        #1;
        on_cmd = 4'h0;
        repeat (3) @(posedge mclk_in);
        #1;
        check({cool, pwr}, 8'h34, "on refused");
        man = 4'h1;
        repeat (2) @(posedge mclk_in);
        #1;
        check({cool, rst_det}, 8'h20, "manual clear");
        $display("Test fault done");
        tally_and_finish();
    end
endmodule : pse_channel_fault_timing_bench
`default_nettype wire
